// ==== design/sac_params.svh ====
// Purpose: constants of the converter control block
// Assumes: 16-bit register port, 4-bit register address
// Notes:   offsets, field positions, reset values and counts
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_ADDR_MODE     4'h0
`define SAC_ADDR_INSEL    4'h1
`define SAC_ADDR_CTRL0    4'h2
`define SAC_ADDR_CTRL1    4'h3
`define SAC_ADDR_PROT     4'h4
`define SAC_ADDR_REF      4'h5
`define SAC_ADDR_RES_BASE 4'h8

`define SAC_MODE_RESET    8'h00
`define SAC_INSEL_RESET   8'hC0
`define SAC_CTRL1_RESET   8'h00
`define SAC_PROT_RESET    8'h00
`define SAC_REF_RESET     8'h00

`define SAC_BIT_START     0
`define SAC_BIT_EXT_IN    0
`define SAC_BIT_TEN       3
`define SAC_BIT_UNDIV     4
`define SAC_BIT_PROT_WE   3
`define SAC_BIT_REF_CONN  0
`define SAC_BIT_SRC       2

`define SAC_CONV_CYCLES   6'd43
`define SAC_LAST_TICK     6'd42
`define SAC_TOP_BIT_TEN   4'd9
`define SAC_TOP_BIT_EIGHT 4'd7
`define SAC_FULL_TEN      10'h3FF
`define SAC_FULL_EIGHT    10'h0FF
`define SAC_CHAN_REF      4'hC
`define SAC_CHAN_NONE     4'hF
`define SAC_GROUP_HIGH    4'h8

`endif

// ==== design/sac_pkg.sv ====
// Purpose: types of the converter control block
// Assumes: nothing beyond the constants header
// Notes:   state of each module is one packed struct
`default_nettype none

package sac_pkg;

  typedef enum logic [2:0] {
    SAC_MODE_SINGLE  = 3'b000,
    SAC_MODE_REPEAT0 = 3'b010,
    SAC_MODE_REPEAT1 = 3'b011,
    SAC_MODE_SWEEP   = 3'b100,
    SAC_MODE_RSWEEP  = 3'b110
  } sac_mode_type;

  typedef enum logic [1:0] {
    SAC_TRIG_SW    = 2'b00,
    SAC_TRIG_TIMER = 2'b10,
    SAC_TRIG_EXT   = 2'b11
  } sac_trig_type;

  typedef enum logic [0:0] {
    SAC_CORE_IDLE = 1'b0,
    SAC_CORE_RUN  = 1'b1
  } sac_core_state_type;

  typedef struct packed {
    sac_core_state_type state;
    logic [5:0]         cnt;
    logic [3:0]         pos;
    logic               ten;
    logic [9:0]         trial;
    logic [9:0]         dac;
    logic [9:0]         result;
    logic               sample;
    logic               done;
  } sac_core_type;

  typedef struct packed {
    logic [4:0]       sync1;
    logic [4:0]       sync2;
    logic [4:0]       prev;
    logic [2:0]       divcnt;
    logic             tick;
    logic [7:0]       mode;
    logic [7:0]       insel;
    logic [7:0]       ctrl1;
    logic [7:0]       prot;
    logic [7:0]       refc;
    logic             busy;
    logic [2:0]       idx;
    logic [3:0]       chan;
    logic             start;
    logic             stop;
    logic [7:0][9:0]  results;
    logic [15:0]      rdata;
  } sac_ctrl_type;

endpackage : sac_pkg

`default_nettype wire

// ==== design/sac_conv_if.sv ====
// Purpose: carrier between sequencer and approximation engine
// Assumes: one clock for both ends
// Notes:   start and stop are one-cycle pulses
`default_nettype none

interface sac_conv_if;
  logic       start;
  logic       stop;
  logic       ten_bit;
  logic       tick;
  logic       comp;
  logic       over;
  logic       done;
  logic       sample;
  logic [9:0] result;
  logic [9:0] dac;

  modport ctrl (output start, stop, ten_bit, tick, comp, over,
                input  done, sample, result, dac);
  modport core (input  start, stop, ten_bit, tick, comp, over,
                output done, sample, result, dac);
endinterface : sac_conv_if

`default_nettype wire

// ==== design/sac_core.sv ====
// Purpose: successive-approximation engine, one channel per start
// Assumes: tick is a one-cycle pulse per conversion clock period
// Notes:   comparator decision is taken on the tick that ends a bit
`include "sac_params.svh"
`default_nettype none

module sac_core (
  input  wire logic clock,
  input  wire logic rst_b,
  sac_conv_if.core  conv
);

  sac_pkg::sac_core_type r_reg;
  sac_pkg::sac_core_type r_next;

  function automatic logic [9:0] sac_onehot(input logic [3:0] pos);
    sac_onehot = 10'(10'h001 << pos);
  endfunction

  always_comb begin
    logic [5:0] first;
    logic [9:0] bitv;
    first = 6'h00;
    bitv = 10'h000;
    r_next = r_reg;
    r_next.done = 1'b0;
    if (conv.stop) begin
      r_next.state = sac_pkg::SAC_CORE_IDLE;
      r_next.sample = 1'b0;
    end else begin
      case (r_reg.state)
        sac_pkg::SAC_CORE_IDLE: begin
          if (conv.start) begin
            r_next.state = sac_pkg::SAC_CORE_RUN;
            r_next.cnt = 6'h00;
            r_next.ten = conv.ten_bit;
            r_next.pos = conv.ten_bit ? `SAC_TOP_BIT_TEN
                                      : `SAC_TOP_BIT_EIGHT;
            r_next.trial = sac_onehot(r_next.pos);
            r_next.sample = 1'b1;
          end
        end
        sac_pkg::SAC_CORE_RUN: begin
          if (conv.tick) begin
            // the same 43 periods in both resolutions; 8-bit waits longer
            first = `SAC_CONV_CYCLES - (r_reg.ten ? 6'd10 : 6'd8);
            r_next.cnt = r_reg.cnt + 6'd1;
            if (r_reg.cnt >= first) begin
              r_next.sample = 1'b0;
              bitv = sac_onehot(r_reg.pos);
              if (!(conv.comp || conv.over)) begin
                r_next.trial = r_reg.trial & ~bitv;
              end
              if (r_reg.pos != 4'd0) begin
                r_next.pos = r_reg.pos - 4'd1;
                r_next.trial = r_next.trial | sac_onehot(r_next.pos);
              end
            end
            if (r_reg.cnt == `SAC_LAST_TICK) begin
              r_next.state = sac_pkg::SAC_CORE_IDLE;
              r_next.done = 1'b1;
              r_next.result = r_next.trial;
              if (conv.over) begin
                r_next.result = r_reg.ten ? `SAC_FULL_TEN
                                          : `SAC_FULL_EIGHT;
              end
            end
          end
        end
        default: r_next.state = sac_pkg::SAC_CORE_IDLE;
      endcase
    end
    r_next.dac = r_next.ten ? r_next.trial
                            : {r_next.trial[7:0], 2'b00};
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign conv.done = r_reg.done;
  assign conv.sample = r_reg.sample;
  assign conv.result = r_reg.result;
  assign conv.dac = r_reg.dac;

endmodule // sac_core

`default_nettype wire

// ==== design/sac_ctrl.sv ====
// Purpose: register file, clocking, triggers and mode sequencing
// Assumes: analog comparator settles within one conversion clock
// Notes:   comparator and triggers arrive through two flip-flops
//
// Contract
// - input above reference returns all ones: 3FFh ten-bit, FFh eight-bit
// - conversion clock is source undivided or divided by 2, 4, 8
// - software selects eight-bit or ten-bit resolution
// - five modes: single, two repeat variants, sweep, repeat sweep
// - multiplexer selects twelve analog channels, zero through eleven; a high-group sweep here can reach channels 12 to 15
// - one channel takes 43 conversion clocks in either resolution
// - reference connect bit joins reference to input path when 1
// - reference register writable only while protect write enable is 1
// - result low eight bits in 0-7, upper two only in ten-bit
// - result bits 10-14 read zero; bit 15 undefined, reads zero here
// - divide field 00 by eight, 01 by four, 1x by two; source bit
// - mode codes 000, 010, 011, 100, 110; others unused
// - trigger codes 00 software, 10 timer, 11 external pin
// - start flag reads 1 while converting, 0 once stopped
//
// Design decisions made here: the address map and strobed register access.
`include "sac_params.svh"
`default_nettype none

module sac_ctrl (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        fast_internal_oscillator,
  input  wire logic        compare_timer_trigger,
  input  wire logic        external_trigger_pin_b,
  input  wire logic        comparator_above,
  input  wire logic        over_reference,
  output logic      [3:0]  analog_channel_select,
  output logic             reference_connect,
  output logic             sample_hold,
  output logic      [9:0]  dac_trial
);

  localparam int SYNC_COMP  = 0;
  localparam int SYNC_OVER  = 1;
  localparam int SYNC_OSC   = 2;
  localparam int SYNC_TIMER = 3;
  localparam int SYNC_EXT   = 4;

  sac_pkg::sac_ctrl_type r_reg;
  sac_pkg::sac_ctrl_type r_next;
  sac_conv_if            conv ();

  // terminal value of the divide counter
  function automatic logic [2:0] sac_div_last(input logic [7:0] mode,
                                              input logic       undiv);
    if (undiv) begin
      sac_div_last = 3'd0;
    end else begin
      case (mode[1:0])
        2'b00:   sac_div_last = 3'd7;
        2'b01:   sac_div_last = 3'd3;
        default: sac_div_last = 3'd1;
      endcase
    end
  endfunction

  function automatic logic [2:0] sac_sweep_last(input logic [7:0] insel);
    sac_sweep_last = {insel[5:4], 1'b1};
  endfunction

  function automatic logic sac_is_sweep(input logic [7:0] mode);
    sac_is_sweep = mode[5];
  endfunction

  // channel driven to the multiplexer for slot idx
  function automatic logic [3:0] sac_chan(input logic [7:0] insel,
                                          input logic [7:0] ctrl1,
                                          input logic [7:0] mode,
                                          input logic [2:0] idx);
    logic [3:0] base;
    base = insel[6] ? `SAC_GROUP_HIGH : 4'h0;
    if (ctrl1[`SAC_BIT_EXT_IN]) begin
      sac_chan = `SAC_CHAN_REF;
    end else if (insel[7:6] == 2'b11 || insel[7:6] == 2'b10) begin
      sac_chan = `SAC_CHAN_NONE;
    end else if (sac_is_sweep(mode)) begin
      sac_chan = base + {1'b0, idx};
    end else if (insel[6] && insel[2]) begin
      sac_chan = `SAC_CHAN_NONE;
    end else begin
      sac_chan = base + {1'b0, insel[2:0]};
    end
  endfunction

  // result register layout seen by software
  function automatic logic [15:0] sac_result_word(input logic [9:0] res,
                                                  input logic       ten);
    sac_result_word = {6'h00, ten ? res[9:8] : 2'b00, res[7:0]};
  endfunction

  always_comb begin
    logic         src_tick;
    logic         launch;
    logic         cont;
    logic [2:0]   slot;
    logic [2:0]   nidx;
    sac_pkg::sac_trig_type trig;
    sac_pkg::sac_mode_type mode;
    src_tick = 1'b0;
    launch = 1'b0;
    cont = 1'b0;
    slot = 3'd0;
    nidx = 3'd0;
    trig = sac_pkg::sac_trig_type'(r_reg.mode[7:6]);
    mode = sac_pkg::sac_mode_type'(r_reg.mode[5:3]);
    r_next = r_reg;
    r_next.sync1 = {external_trigger_pin_b, compare_timer_trigger,
                    fast_internal_oscillator, over_reference,
                    comparator_above};
    r_next.sync2 = r_reg.sync1;
    r_next.prev = r_reg.sync2;
    r_next.start = 1'b0;
    r_next.stop = 1'b0;
    r_next.tick = 1'b0;
    r_next.rdata = 16'h0000;

    // source clock: system clock every cycle or oscillator rising edge
    src_tick = r_reg.mode[`SAC_BIT_SRC] ?
               (r_reg.sync2[SYNC_OSC] && !r_reg.prev[SYNC_OSC]) :
               1'b1;
    if (src_tick) begin
      if (r_reg.divcnt >= sac_div_last(r_reg.mode,
                                       r_reg.ctrl1[`SAC_BIT_UNDIV])) begin
        r_next.divcnt = 3'd0;
        r_next.tick = 1'b1;
      end else begin
        r_next.divcnt = r_reg.divcnt + 3'd1;
      end
    end

    // restart the divider with each channel: a free-running phase could
    // shorten the first period and the conversion below 43 whole periods
    if (r_reg.start) begin
      r_next.divcnt = 3'd0;
      r_next.tick = 1'b0;
    end

    // hardware triggers start a conversion only while idle
    if (!r_reg.busy) begin
      if (trig == sac_pkg::SAC_TRIG_TIMER &&
          r_reg.sync2[SYNC_TIMER] && !r_reg.prev[SYNC_TIMER]) begin
        launch = 1'b1;
      end
      if (trig == sac_pkg::SAC_TRIG_EXT &&
          !r_reg.sync2[SYNC_EXT] && r_reg.prev[SYNC_EXT]) begin
        launch = 1'b1;
      end
    end

    if (reg_wr) begin
      case (reg_addr)
        `SAC_ADDR_MODE:  r_next.mode = reg_wdata[7:0];
        `SAC_ADDR_INSEL: r_next.insel = reg_wdata[7:0];
        `SAC_ADDR_CTRL1: r_next.ctrl1 = reg_wdata[7:0];
        `SAC_ADDR_PROT:  r_next.prot = reg_wdata[7:0];
        `SAC_ADDR_REF: begin
          if (r_reg.prot[`SAC_BIT_PROT_WE]) begin
            r_next.refc = reg_wdata[7:0];
          end
        end
        `SAC_ADDR_CTRL0: begin
          if (reg_wdata[`SAC_BIT_START]) begin
            if (!r_reg.busy && trig == sac_pkg::SAC_TRIG_SW) begin
              launch = 1'b1;
            end
          end else if (r_reg.busy) begin
            r_next.busy = 1'b0;
            r_next.stop = 1'b1;
          end
        end
        default: r_next.rdata = 16'h0000;
      endcase
    end

    // a finished channel is stored, then the mode picks what follows
    if (conv.done && r_reg.busy && !r_next.stop) begin
      slot = (mode == sac_pkg::SAC_MODE_SINGLE ||
              mode == sac_pkg::SAC_MODE_REPEAT0) ? 3'd0 : r_reg.idx;
      r_next.results[slot] = conv.result;
      nidx = r_reg.idx + 3'd1;
      case (mode)
        sac_pkg::SAC_MODE_SINGLE: cont = 1'b0;
        sac_pkg::SAC_MODE_REPEAT0: begin
          cont = 1'b1;
          nidx = 3'd0;
        end
        sac_pkg::SAC_MODE_REPEAT1: cont = 1'b1;
        sac_pkg::SAC_MODE_SWEEP: begin
          cont = r_reg.idx != sac_sweep_last(r_reg.insel);
        end
        sac_pkg::SAC_MODE_RSWEEP: begin
          cont = 1'b1;
          if (r_reg.idx == sac_sweep_last(r_reg.insel)) begin
            nidx = 3'd0;
          end
        end
        default: cont = 1'b0;
      endcase
      if (cont) begin
        r_next.idx = nidx;
        r_next.chan = sac_chan(r_reg.insel, r_reg.ctrl1, r_reg.mode,
                               nidx);
        r_next.start = 1'b1;
      end else begin
        r_next.busy = 1'b0;
      end
    end

    if (launch) begin
      r_next.busy = 1'b1;
      r_next.idx = 3'd0;
      r_next.chan = sac_chan(r_reg.insel, r_reg.ctrl1, r_reg.mode, 3'd0);
      r_next.start = 1'b1;
    end

    if (reg_rd) begin
      case (reg_addr)
        `SAC_ADDR_MODE:  r_next.rdata = {8'h00, r_reg.mode};
        `SAC_ADDR_INSEL: r_next.rdata = {8'h00, r_reg.insel};
        `SAC_ADDR_CTRL0: r_next.rdata = {15'h0000, r_reg.busy};
        `SAC_ADDR_CTRL1: r_next.rdata = {8'h00, r_reg.ctrl1};
        `SAC_ADDR_PROT:  r_next.rdata = {8'h00, r_reg.prot};
        `SAC_ADDR_REF:   r_next.rdata = {8'h00, r_reg.refc};
        default: begin
          if (reg_addr[3]) begin
            r_next.rdata = sac_result_word(r_reg.results[reg_addr[2:0]],
                                           r_reg.ctrl1[`SAC_BIT_TEN]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.mode <= `SAC_MODE_RESET;
      r_reg.insel <= `SAC_INSEL_RESET;
      r_reg.ctrl1 <= `SAC_CTRL1_RESET;
      r_reg.prot <= `SAC_PROT_RESET;
      r_reg.refc <= `SAC_REF_RESET;
      r_reg.chan <= `SAC_CHAN_NONE;
      r_reg.sync1 <= 5'h10;
      r_reg.sync2 <= 5'h10;
      r_reg.prev <= 5'h10;
    end else begin
      r_reg <= r_next;
    end
  end

  // the comparator copies come from the second synchroniser stage
  assign conv.start = r_reg.start;
  assign conv.stop = r_reg.stop;
  assign conv.ten_bit = r_reg.ctrl1[`SAC_BIT_TEN];
  assign conv.tick = r_reg.tick;
  assign conv.comp = r_reg.sync2[SYNC_COMP];
  assign conv.over = r_reg.sync2[SYNC_OVER];

  sac_core u_core (
    .clock (clock),
    .rst_b (rst_b),
    .conv  (conv.core)
  );

  assign reg_rdata = r_reg.rdata;
  assign analog_channel_select = r_reg.chan;
  assign reference_connect = r_reg.refc[`SAC_BIT_REF_CONN];
  assign sample_hold = conv.sample;
  assign dac_trial = conv.dac;

endmodule // sac_ctrl

`default_nettype wire

// ==== verification/sac_analog_model.sv ====
// Purpose: analog side of the converter: channel levels and comparator
// Assumes: each input sits on its ten-bit code, a quarter lsb above its eight-bit code
// Notes:   level of a channel is {channel, 6'h15}; oscillator is clock/4
`default_nettype none

module sac_analog_model (
  input  wire logic       clock,
  input  wire logic       over,
  input  wire logic [3:0] chan,
  input  wire logic [9:0] dac,
  output logic            above,
  output logic            over_ref,
  output logic            osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] lvl;
  logic [1:0] div = 2'h0;
  // distinct level per channel so a wrong mux choice shows in the result
  assign lvl = {chan, 6'h15};
  assign above = (lvl >= dac);
  assign over_ref = over;
  always @(posedge clock) div <= div + 2'h1;
  assign osc = div[1];
endmodule // sac_analog_model

`default_nettype wire

// ==== verification/sac_ctrl_assertions.sv ====
// Purpose: port-level checks of the converter control block
// Assumes: register map and bit positions of the constants header
// Notes:   protect and resolution bits are shadowed from bus writes
`include "sac_params.svh"
`default_nettype none

module sac_ctrl_assertions (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0]  analog_channel_select,
  input wire logic        reference_connect,
  input wire logic        sample_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prot_we_reg;
  logic ten_reg;
  logic ref_wr;
  assign ref_wr = reg_wr && reg_addr == `SAC_ADDR_REF;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prot_we_reg <= 1'b0;
      ten_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `SAC_ADDR_PROT)
        prot_we_reg <= reg_wdata[`SAC_BIT_PROT_WE];
      if (reg_addr == `SAC_ADDR_CTRL1)
        ten_reg <= reg_wdata[`SAC_BIT_TEN];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  ref_locked_a: assert property (
    ref_wr && !prot_we_reg |=> $stable(reference_connect))
    else $error("locked reference register changed");
  ref_write_a: assert property (
    ref_wr && prot_we_reg |=> reference_connect == $past(reg_wdata[0]))
    else $error("reference connect does not follow write");
  ref_hold_a: assert property (
    !ref_wr |=> $stable(reference_connect))
    else $error("reference connect moved without a write");
  result_top_a: assert property (
    reg_rd && reg_addr[3] |=> reg_rdata[15:10] == 6'h00)
    else $error("result bits 15..10 not zero");
  eight_upper_a: assert property (
    reg_rd && reg_addr[3] && !ten_reg |=> reg_rdata[9:8] == 2'h0)
    else $error("eight-bit result shows upper bits");
  flag_only_a: assert property (
    reg_rd && reg_addr == `SAC_ADDR_CTRL0 |=> reg_rdata[15:1] == 15'h0000)
    else $error("control0 read shows more than the flag");
  chan_range_a: assert property (
    analog_channel_select <= 4'hC || analog_channel_select == 4'hF)
    else $error("channel select out of range");
  sample_chan_a: assert property (
    sample_hold |-> analog_channel_select != 4'hF)
    else $error("sampling with no channel");
  chan_steady_a: assert property (
    sample_hold && $past(sample_hold) |-> $stable(analog_channel_select))
    else $error("channel changed while sampling");
  sample_span_a: assert property (
    $rose(sample_hold) |-> sample_hold [*8] ##[1:320] !sample_hold)
    else $error("sample phase too short or too long");
endmodule // sac_ctrl_assertions

bind sac_ctrl sac_ctrl_assertions chk_u (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .analog_channel_select(analog_channel_select),
  .reference_connect(reference_connect), .sample_hold(sample_hold)
);

`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench of the converter control block
// Assumes: analog model on the far side, divide-by-4 or 8 for accuracy
// Notes:   busy is polled with back-to-back reads, two cycles apiece
`include "sac_params.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        timer_trig = 1'b0;
  logic        ext_trig_b = 1'b1;
  logic        over = 1'b0;
  logic        osc, above, over_ref, reference_connect, sample_hold;
  logic [15:0] reg_rdata;
  logic [3:0]  chan;
  logic [9:0]  dac;
  int          errors = 0;
  int          n_tests = 0;

  sac_ctrl dut_u (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fast_internal_oscillator(osc),
    .compare_timer_trigger(timer_trig), .external_trigger_pin_b(ext_trig_b),
    .comparator_above(above), .over_reference(over_ref),
    .analog_channel_select(chan), .reference_connect(reference_connect),
    .sample_hold(sample_hold), .dac_trial(dac));
  sac_analog_model mdl_u (
    .clock(clock), .over(over), .chan(chan), .dac(dac),
    .above(above), .over_ref(over_ref), .osc(osc));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= {8'h00, d};
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e,
                      input string w);
    logic [15:0] d;
    rd(a, d);
    chk(w, e, d);
  endtask

  // no configuration write is issued until busy has dropped
  task automatic wait_idle(output int cyc);
    logic [15:0] d;
    cyc = 0;
    d = 16'h0001;
    while (d[0] !== 1'b0 && cyc < 2000) begin
      rd(`SAC_ADDR_CTRL0, d);
      cyc += 2;
    end
    if (cyc >= 2000) chk("busy timeout", 16'h0000, d);
  endtask

  task automatic conv(output int cyc);
    wr(`SAC_ADDR_CTRL0, 8'h01);
    wait_idle(cyc);
  endtask

  task automatic t_reset;
    rchk(`SAC_ADDR_MODE, 16'h0000, "mode reset");
    rchk(`SAC_ADDR_INSEL, 16'h00C0, "insel reset");
    rchk(`SAC_ADDR_CTRL1, 16'h0000, "ctrl1 reset");
    rchk(`SAC_ADDR_PROT, 16'h0000, "prot reset");
    rchk(`SAC_ADDR_REF, 16'h0000, "ref reset");
    rchk(4'h6, 16'h0000, "unmapped");
    chk("idle channel", 16'h000F, {12'h000, chan});
  endtask

  task automatic t_ref;
    int c;
    wr(`SAC_ADDR_REF, 8'h01);
    rchk(`SAC_ADDR_REF, 16'h0000, "ref locked");
    wr(`SAC_ADDR_CTRL1, 8'h01);
    wr(`SAC_ADDR_PROT, 8'h08);
    wr(`SAC_ADDR_REF, 8'h01);
    rchk(`SAC_ADDR_REF, 16'h0001, "ref open");
    chk("connect on", 16'h0001, {15'h0000, reference_connect});
    conv(c);
    rchk(`SAC_ADDR_RES_BASE, 16'h00C5, "reference result");
    wr(`SAC_ADDR_REF, 8'h00);
    wr(`SAC_ADDR_CTRL1, 8'h00);
    chk("connect off", 16'h0000, {15'h0000, reference_connect});
    wr(`SAC_ADDR_PROT, 8'h00);
  endtask

  task automatic t_clock;
    logic [7:0] md [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h04};
    logic [7:0] c1 [6] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h18, 8'h18};
    int f [6] = '{8, 4, 2, 2, 1, 4};
    int c;
    over <= 1'b1;
    wr(`SAC_ADDR_INSEL, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(`SAC_ADDR_MODE, md[i]);
      wr(`SAC_ADDR_CTRL1, c1[i]);
      conv(c);
      chk("conv time", 16'h0001,
          16'(c >= 43 * f[i] && c <= 44 * f[i] + 12));
      rchk(`SAC_ADDR_RES_BASE, 16'h03FF, "full ten");
    end
    // back to the system clock: oscillator divided by 8 samples too long
    wr(`SAC_ADDR_MODE, 8'h00);
    wr(`SAC_ADDR_CTRL1, 8'h00);
    conv(c);
    rchk(`SAC_ADDR_RES_BASE, 16'h00FF, "full eight");
    over <= 1'b0;
  endtask

  task automatic t_value;
    int c;
    wr(`SAC_ADDR_MODE, 8'h00);
    wr(`SAC_ADDR_INSEL, 8'h43);
    wr(`SAC_ADDR_CTRL1, 8'h08);
    conv(c);
    rchk(`SAC_ADDR_RES_BASE, 16'h02D5, "ten channel 11");
    wr(`SAC_ADDR_INSEL, 8'h03);
    wr(`SAC_ADDR_CTRL1, 8'h00);
    conv(c);
    rchk(`SAC_ADDR_RES_BASE, 16'h0035, "eight channel 3");
  endtask

  task automatic t_modes;
    logic [7:0] rm [3] = '{8'h11, 8'h19, 8'h31};
    // each slot checked holds a different value before that mode runs
    logic [3:0] sl [3] = '{4'h8, 4'hA, 4'hA};
    logic [15:0] rx [3] = '{16'h0255, 16'h0255, 16'h0295};
    int c;
    wr(`SAC_ADDR_CTRL1, 8'h08);
    wr(`SAC_ADDR_INSEL, 8'h51);
    wr(`SAC_ADDR_MODE, 8'h21);
    conv(c);
    for (int k = 0; k < 4; k++) begin
      rchk(`SAC_ADDR_RES_BASE + 4'(k),
           {6'h00, 4'(8 + k), 6'h15}, "sweep slot");
    end
    for (int i = 0; i < 3; i++) begin
      wr(`SAC_ADDR_MODE, rm[i]);
      wr(`SAC_ADDR_CTRL0, 8'h01);
      repeat (600) @(posedge clock);
      rchk(`SAC_ADDR_CTRL0, 16'h0001, "still busy");
      rchk(sl[i], rx[i], "repeat slot");
      wr(`SAC_ADDR_CTRL0, 8'h00);
      rchk(`SAC_ADDR_CTRL0, 16'h0000, "stopped");
    end
  endtask

  task automatic t_trig;
    int c;
    wr(`SAC_ADDR_MODE, 8'h81);
    wr(`SAC_ADDR_CTRL0, 8'h01);
    rchk(`SAC_ADDR_CTRL0, 16'h0000, "soft start refused");
    timer_trig <= 1'b1;
    repeat (4) @(posedge clock);
    rchk(`SAC_ADDR_CTRL0, 16'h0001, "timer start");
    timer_trig <= 1'b0;
    wait_idle(c);
    wr(`SAC_ADDR_MODE, 8'hC1);
    ext_trig_b <= 1'b0;
    repeat (4) @(posedge clock);
    rchk(`SAC_ADDR_CTRL0, 16'h0001, "pin start");
    ext_trig_b <= 1'b1;
    wait_idle(c);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_reset;
    t_ref;
    t_clock;
    t_value;
    t_modes;
    t_trig;
    give_verdict;
  end

  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    give_verdict;
  end
endmodule // tb

`default_nettype wire
